// [include/ltd_pkg.sv]
package ltd_pkg;
   // Register word indices; byte address is four times the index
   localparam logic [7:0] IDX_TX_CONFIG_A = 8'h02;
   localparam logic [7:0] IDX_TX_CONFIG_B = 8'h03;
   localparam logic [7:0] IDX_TERM_SEL = 8'h1a;
   localparam logic [7:0] IDX_MODE_CTRL = 8'h30;
   localparam logic [7:0] IDX_WAVE_ADDR = 8'h31;
   localparam logic [7:0] IDX_WAVE_DATA = 8'h32;
   localparam logic [7:0] IDX_STATUS = 8'h33;

   // transmit_config_a fields
   localparam int TXA_POWER_DOWN_BIT = 7;
   localparam int TXA_PULSE_LSB = 0;
   localparam logic [7:0] TXA_RESET = 8'h00;
   // transmit_config_b fields
   localparam int TXB_TRISTATE_BIT = 7;
   localparam int TXB_SCALE_LSB = 0;
   localparam logic [7:0] TXB_RESET = 8'h36;
   // line_termination_select fields
   localparam int TERM_TX_LSB = 3;
   localparam int TERM_RX_LSB = 0;
   localparam int TERM_EXT_BIT = 2;
   localparam logic [7:0] TERM_RESET = 8'h00;
   // mode_ctrl fields
   localparam int MODE_LOOPBACK_BIT = 0;
   localparam int MODE_INT_PATTERN_BIT = 1;
   localparam int MODE_SOFT_RESET_BIT = 2;
   localparam int MODE_RELEASE_BIT = 3;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // Amplitude scaling: unity at 54, 2 % per step
   localparam logic [5:0] SCALE_OFFSET = 6'h04;
   localparam logic [11:0] SCALE_DIVISOR = 12'h032;
   localparam logic [3:0] PULSE_T1_LONGEST = 4'h6;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Reset contents of the waveform table: address = {unit interval, sample}
   function automatic logic [6:0] waveInit(input logic [5:0] addr);
      logic [6:0] v;
      v = 7'h00;
      if (addr[5:4] == 2'h0) begin
         case (addr[3:0])
            4'h0: v = 7'h20;
            4'h1: v = 7'h3f;
            4'h2: v = 7'h38;
            4'h3: v = 7'h33;
            4'h4: v = 7'h2f;
            4'h5: v = 7'h2e;
            4'h6: v = 7'h2d;
            4'h7: v = 7'h2c;
            4'h8: v = 7'h29;
            4'h9: v = 7'h5f;
            4'ha: v = 7'h5e;
            4'hb: v = 7'h57;
            4'hc: v = 7'h4f;
            4'hd: v = 7'h49;
            4'he: v = 7'h47;
            default: v = 7'h44;
         endcase
      end else if (addr[5:4] == 2'h1) begin
         case (addr[3:0])
            4'h0: v = 7'h43;
            4'h1: v = 7'h42;
            4'h2: v = 7'h41;
            default: v = 7'h00;
         endcase
      end
      return v;
   endfunction : waveInit
endpackage : ltd_pkg

// [include/ltd_tbl_if.sv]
`timescale 1ns/100ps
interface ltd_tbl_if;
   logic wrEn;
   logic [5:0] wrAddr;
   logic [6:0] wrData;
   logic [5:0] rdAddrA;
   logic [6:0] rdDataA;
   logic [5:0] rdAddrB;
   logic [6:0] rdDataB;
   modport mem (input wrEn, input wrAddr, input wrData, input rdAddrA, input rdAddrB,
      output rdDataA, output rdDataB);
   modport user (output wrEn, output wrAddr, output wrData, output rdAddrA, output rdAddrB,
      input rdDataA, input rdDataB);
endinterface : ltd_tbl_if

// [design/ltd_wave_mem.sv]
`timescale 1ns/100ps
module ltd_wave_mem (
   input wire logic clk,
   input wire logic sys_rst,
   ltd_tbl_if.mem tbl
);
   logic [6:0] mem_r [0:63];

   // Table comes up holding the longest T1 band template
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 64; i++) begin
            mem_r[i] <= ltd_pkg::waveInit(6'(i)); // RQ12
         end
      end else if (tbl.wrEn) begin
         mem_r[tbl.wrAddr] <= tbl.wrData;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tbl.rdDataA <= 7'h00;
         tbl.rdDataB <= 7'h00;
      end else begin
         tbl.rdDataA <= mem_r[tbl.rdAddrA];
         tbl.rdDataB <= mem_r[tbl.rdAddrB];
      end
   end
endmodule : ltd_wave_mem

// [design/ltd_top.sv]
// Overview of operation
// RQ1: Transmit termination bit2 low selects internal ohms
// RQ2: Software avoids external transmit matching in T1/J1
// RQ3: Tristate pin or channel bit floats transmit pair
// RQ4: Master clock loss floats the transmit pair
// RQ5: Transmit clock loss floats, except loopback/pattern
// RQ6: Any reset leaves the transmit pair floating
// RQ7: Power-down bit stops path and floats pair
// RQ8: Receive termination bit2 low selects internal ohms
// RQ9: Software sets pulse template code per cable
// RQ10: Software sets transmit termination code per cable
// RQ11: Software sets receive termination code per cable
// RQ12: Hold 64-entry 7-bit longest-T1 pulse template
// RQ13: Six-bit scale, default 110110, 2% per step
// RQ14: Driver enabled only when no float cause active
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ltd_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tx_tristate,
   input wire logic masterClockLost,
   input wire logic txClockLost,
   input wire logic txDataPos,
   input wire logic txDataNeg,
   output logic tx_line_pos_o,
   output logic tx_line_pos_oe,
   output logic tx_line_neg_o,
   output logic tx_line_neg_oe,
   output logic txTermInternal_r,
   output logic [1:0] txTermOhms_r,
   output logic rxTermInternal_r,
   output logic [1:0] rxTermOhms_r,
   output logic txPathPowerDown_r,
   output logic [3:0] pulse_template_sel_r,
   output logic [6:0] waveSample_r
);
   logic [7:0] txConfigA_r;
   logic [7:0] txConfigB_r;
   logic [7:0] termSel_r;
   logic [7:0] modeCtrl_r;
   logic [5:0] waveAddr_r;
   logic resetHold_r;
   logic awHeld_r;
   logic wHeld_r;
   logic [7:0] awIdx_r;
   logic [7:0] wData_r;
   logic wLane_r;
   logic [5:0] playAddr_r;
   logic [7:0] rdIdx;
   logic [7:0] rdVal;
   logic doWrite;
   logic softReset;
   logic floatCause;
   logic [11:0] scaledMag;
   logic [5:0] scaleStep;

   ltd_tbl_if tbl ();

   ltd_wave_mem u_mem (
      .clk(clk),
      .sys_rst(sys_rst),
      .tbl(tbl.mem)
   );

   function automatic logic isMapped(input logic [7:0] idx);
      return idx == ltd_pkg::IDX_TX_CONFIG_A || idx == ltd_pkg::IDX_TX_CONFIG_B ||
         idx == ltd_pkg::IDX_TERM_SEL || idx == ltd_pkg::IDX_MODE_CTRL ||
         idx == ltd_pkg::IDX_WAVE_ADDR || idx == ltd_pkg::IDX_WAVE_DATA ||
         idx == ltd_pkg::IDX_STATUS;
   endfunction : isMapped

   // Write channel: address and data captured in either order
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awIdx_r <= 8'h00;
         wData_r <= 8'h00;
         wLane_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ltd_pkg::RESP_OKAY;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         // Ready flops track !held && !bvalid: low from capture to the response handshake
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awIdx_r <= s_axi_awaddr[9:2];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata[7:0];
            wLane_r <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(awIdx_r) ? ltd_pkg::RESP_OKAY : ltd_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign softReset = doWrite && wLane_r && awIdx_r == ltd_pkg::IDX_MODE_CTRL &&
      wData_r[ltd_pkg::MODE_SOFT_RESET_BIT];

   // Configuration registers; a soft reset restores their reset values
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         txConfigA_r <= ltd_pkg::TXA_RESET;
         txConfigB_r <= ltd_pkg::TXB_RESET; // RQ13
         termSel_r <= ltd_pkg::TERM_RESET;
         modeCtrl_r <= ltd_pkg::MODE_RESET;
         waveAddr_r <= 6'h00;
      end else if (softReset) begin
         txConfigA_r <= ltd_pkg::TXA_RESET;
         txConfigB_r <= ltd_pkg::TXB_RESET; // RQ13
         termSel_r <= ltd_pkg::TERM_RESET;
         modeCtrl_r <= ltd_pkg::MODE_RESET;
         waveAddr_r <= 6'h00;
      end else if (doWrite && wLane_r) begin
         case (awIdx_r)
            ltd_pkg::IDX_TX_CONFIG_A: txConfigA_r <= wData_r;
            ltd_pkg::IDX_TX_CONFIG_B: txConfigB_r <= wData_r;
            ltd_pkg::IDX_TERM_SEL: termSel_r <= {2'h0, wData_r[5:0]};
            ltd_pkg::IDX_MODE_CTRL: modeCtrl_r <= {6'h00, wData_r[1:0]};
            ltd_pkg::IDX_WAVE_ADDR: waveAddr_r <= wData_r[5:0];
            default: ;
         endcase
      end
   end

   assign tbl.wrEn = doWrite && wLane_r && awIdx_r == ltd_pkg::IDX_WAVE_DATA;
   assign tbl.wrAddr = waveAddr_r;
   assign tbl.wrData = wData_r[6:0];
   assign tbl.rdAddrA = waveAddr_r;
   assign tbl.rdAddrB = playAddr_r;

   // Driver stays floating after any reset until software releases it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         resetHold_r <= 1'b1; // RQ6
      end else if (softReset) begin
         resetHold_r <= 1'b1; // RQ6
      end else if (doWrite && wLane_r && awIdx_r == ltd_pkg::IDX_MODE_CTRL &&
         wData_r[ltd_pkg::MODE_RELEASE_BIT]) begin
         resetHold_r <= 1'b0;
      end
   end

   // Read channel: one request at a time, data registered
   assign rdIdx = s_axi_araddr[9:2];
   always_comb begin
      case (rdIdx)
         ltd_pkg::IDX_TX_CONFIG_A: rdVal = txConfigA_r;
         ltd_pkg::IDX_TX_CONFIG_B: rdVal = txConfigB_r;
         ltd_pkg::IDX_TERM_SEL: rdVal = termSel_r;
         ltd_pkg::IDX_MODE_CTRL: rdVal = modeCtrl_r;
         ltd_pkg::IDX_WAVE_ADDR: rdVal = {2'h0, waveAddr_r};
         ltd_pkg::IDX_WAVE_DATA: rdVal = {1'b0, tbl.rdDataA};
         ltd_pkg::IDX_STATUS: rdVal = {3'h0, resetHold_r, masterClockLost, txClockLost,
            txTermInternal_r, tx_line_pos_oe};
         default: rdVal = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= ltd_pkg::RESP_OKAY;
         s_axi_arready <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rdVal};
         s_axi_rresp <= isMapped(rdIdx) ? ltd_pkg::RESP_OKAY : ltd_pkg::RESP_SLVERR;
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Any single cause floats the pair
   assign floatCause = tx_tristate || txConfigB_r[ltd_pkg::TXB_TRISTATE_BIT] || // RQ3
      masterClockLost || // RQ4
      (txClockLost && !modeCtrl_r[ltd_pkg::MODE_LOOPBACK_BIT] &&
      !modeCtrl_r[ltd_pkg::MODE_INT_PATTERN_BIT]) || // RQ5
      txConfigA_r[ltd_pkg::TXA_POWER_DOWN_BIT] || // RQ7
      resetHold_r || softReset; // RQ14

   // Line pins; data keeps flowing while floated, except under power-down, which forces both data pins low
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_line_pos_oe <= 1'b0; // RQ6
         tx_line_neg_oe <= 1'b0;
         tx_line_pos_o <= 1'b0;
         tx_line_neg_o <= 1'b0;
      end else begin
         tx_line_pos_oe <= !floatCause; // RQ14
         tx_line_neg_oe <= !floatCause; // RQ14
         tx_line_pos_o <= txDataPos && !txConfigA_r[ltd_pkg::TXA_POWER_DOWN_BIT]; // RQ7
         tx_line_neg_o <= txDataNeg && !txConfigA_r[ltd_pkg::TXA_POWER_DOWN_BIT];
      end
   end

   // Termination and template controls
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         txTermInternal_r <= 1'b1;
         txTermOhms_r <= 2'h0;
         rxTermInternal_r <= 1'b1;
         rxTermOhms_r <= 2'h0;
         txPathPowerDown_r <= 1'b0;
         pulse_template_sel_r <= 4'h0;
      end else begin
         txTermInternal_r <= !termSel_r[ltd_pkg::TERM_TX_LSB + ltd_pkg::TERM_EXT_BIT]; // RQ1
         txTermOhms_r <= termSel_r[ltd_pkg::TERM_TX_LSB +: 2]; // RQ1
         rxTermInternal_r <= !termSel_r[ltd_pkg::TERM_RX_LSB + ltd_pkg::TERM_EXT_BIT]; // RQ8
         rxTermOhms_r <= termSel_r[ltd_pkg::TERM_RX_LSB +: 2]; // RQ8
         txPathPowerDown_r <= txConfigA_r[ltd_pkg::TXA_POWER_DOWN_BIT]; // RQ7
         pulse_template_sel_r <= txConfigA_r[ltd_pkg::TXA_PULSE_LSB +: 4];
      end
   end

   // Template playback with amplitude scaling: gain = (scale - 4) / 50
   assign scaleStep = (txConfigB_r[5:0] > ltd_pkg::SCALE_OFFSET) ?
      6'(txConfigB_r[5:0] - ltd_pkg::SCALE_OFFSET) : 6'h00;
   assign scaledMag = 12'({6'h00, tbl.rdDataB[5:0]} * {6'h00, scaleStep}) / ltd_pkg::SCALE_DIVISOR; // RQ13

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         playAddr_r <= 6'h00;
         waveSample_r <= 7'h00;
      end else begin
         if (!txConfigA_r[ltd_pkg::TXA_POWER_DOWN_BIT] &&
            txConfigA_r[ltd_pkg::TXA_PULSE_LSB +: 4] == ltd_pkg::PULSE_T1_LONGEST) begin
            playAddr_r <= 6'(playAddr_r + 6'h01); // RQ12
         end else begin
            playAddr_r <= 6'h00;
         end
         waveSample_r <= {tbl.rdDataB[6], (scaledMag > 12'h03f) ? 6'h3f : scaledMag[5:0]}; // RQ13
      end
   end
endmodule : ltd_top

// [tb/ltd_line_model.sv]
`timescale 1ns/100ps
module ltd_line_model (
   input wire logic clk,
   input wire logic posO,
   input wire logic posOe,
   input wire logic negO,
   input wire logic negOe,
   output logic posWire = 1'b0,
   output logic negWire = 1'b0
);
   // A floating pair shows the inverse of what the driver would put out
   always @(posedge clk) begin
      posWire <= posOe ? posO : !posO;
      negWire <= negOe ? negO : !negO;
   end
endmodule : ltd_line_model

// [tb/ltd_top_assertions.sv]
`timescale 1ns/100ps
module ltd_top_assertions (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tx_tristate,
   input wire logic masterClockLost,
   input wire logic txDataPos,
   input wire logic txDataNeg,
   input wire logic txPathPowerDown_r,
   input wire logic tx_line_pos_o,
   input wire logic tx_line_pos_oe,
   input wire logic tx_line_neg_o,
   input wire logic tx_line_neg_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence pdHeld;
      txPathPowerDown_r ##1 txPathPowerDown_r;
   endsequence
   pin_float_a: assert property (tx_tristate |=> !tx_line_pos_oe && !tx_line_neg_oe)
      else $error("tristate pin left pair driven");
   mclk_float_a: assert property (masterClockLost |=> !tx_line_pos_oe)
      else $error("master clock loss left pair driven");
   pd_float_a: assert property (pdHeld |-> !tx_line_pos_oe && !tx_line_pos_o && !tx_line_neg_o)
      else $error("power-down left pair active");
   pair_oe_a: assert property (tx_line_pos_oe == tx_line_neg_oe)
      else $error("pair enables differ");
   rst_float_a: assert property ($past(sys_rst) |-> !tx_line_pos_oe)
      else $error("pair driven right after reset");
   oe_cause_a: assert property ($rose(tx_line_pos_oe) |->
      !$past(tx_tristate) && !$past(masterClockLost) && !txPathPowerDown_r)
      else $error("driver enabled with a float cause");
   pos_data_a: assert property (tx_line_pos_oe |-> tx_line_pos_o == $past(txDataPos))
      else $error("positive pin data wrong");
   neg_data_a: assert property (tx_line_neg_oe |-> tx_line_neg_o == $past(txDataNeg))
      else $error("negative pin data wrong");
endmodule : ltd_top_assertions
bind ltd_top ltd_top_assertions u_ltd_top_assertions (.clk, .sys_rst, .tx_tristate, .masterClockLost,
   .txDataPos, .txDataNeg, .txPathPowerDown_r, .tx_line_pos_o, .tx_line_pos_oe, .tx_line_neg_o, .tx_line_neg_oe);

// [tb/line_termination_driver_control_test.sv]
`timescale 1ns/100ps
module line_termination_driver_control_test;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, txTermOhms_r, rxTermOhms_r;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic tx_tristate = 1'b0, masterClockLost = 1'b0, txClockLost = 1'b0, txDataPos = 1'b0, txDataNeg = 1'b0;
   logic tx_line_pos_o, tx_line_pos_oe, tx_line_neg_o, tx_line_neg_oe, txTermInternal_r, rxTermInternal_r;
   logic txPathPowerDown_r, posWire, negWire;
   logic [3:0] pulse_template_sel_r;
   logic [6:0] waveSample_r;
   logic [31:0] rnd = 32'hb9c9;
   int bad_count = 0, comparisons = 0, cyc = 0;

   ltd_top u_ltd_top (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .tx_tristate, .masterClockLost, .txClockLost, .txDataPos, .txDataNeg, .tx_line_pos_o,
      .tx_line_pos_oe, .tx_line_neg_o, .tx_line_neg_oe, .txTermInternal_r, .txTermOhms_r, .rxTermInternal_r,
      .rxTermOhms_r, .txPathPowerDown_r, .pulse_template_sel_r, .waveSample_r);
   ltd_line_model u_ltd_line_model (.clk, .posO(tx_line_pos_o), .posOe(tx_line_pos_oe), .negO(tx_line_neg_o),
      .negOe(tx_line_neg_oe), .posWire, .negWire);

   initial forever #4 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [6:0] expWave(input logic [5:0] a);
      logic [6:0] ui1 [16] = '{7'h20, 7'h3f, 7'h38, 7'h33, 7'h2f, 7'h2e, 7'h2d, 7'h2c,
         7'h29, 7'h5f, 7'h5e, 7'h57, 7'h4f, 7'h49, 7'h47, 7'h44};
      if (a[5:4] == 2'h0) return ui1[a[3:0]];
      if (a[5:4] == 2'h1 && a[3:0] < 4'h3) return 7'h43 - {3'h0, a[3:0]};
      return 7'h00;
   endfunction : expWave
   // Amplitude gain (scale - offset) / divisor, magnitude clamped at 63
   function automatic logic [6:0] expScaled(input logic [6:0] v, input logic [5:0] s);
      int m;
      m = 0;
      if (s > ltd_pkg::SCALE_OFFSET) begin
         m = int'(v[5:0]) * int'(s - ltd_pkg::SCALE_OFFSET) / int'(ltd_pkg::SCALE_DIVISOR);
      end
      return {v[6], (m > 63) ? 6'h3f : 6'(m)};
   endfunction : expScaled

   task automatic final_report;
      if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic axWrite(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] er = ltd_pkg::RESP_OKAY);
      @(posedge clk);
      s_axi_awaddr <= {22'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : axWrite
   task automatic axRead(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er = ltd_pkg::RESP_OKAY);
      @(posedge clk);
      s_axi_araddr <= {22'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : axRead
   task automatic oeIs(input logic e);
      repeat (3) @(posedge clk);
      chk("oe", {31'h0, e}, {31'h0, tx_line_pos_oe});
   endtask : oeIs
   task automatic setCause(input int c, input logic v);
      case (c)
         0: tx_tristate <= v;
         1: masterClockLost <= v;
         2: txClockLost <= v;
         3: axWrite(ltd_pkg::IDX_TX_CONFIG_B, {v, 7'h36});
         default: axWrite(ltd_pkg::IDX_TX_CONFIG_A, {v, 7'h01});
      endcase
   endtask : setCause

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         bad_count++;
         final_report();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      oeIs(1'b0);
      chk("txInt", 32'h1, {31'h0, txTermInternal_r});
      chk("rxInt", 32'h1, {31'h0, rxTermInternal_r});
      axRead(ltd_pkg::IDX_TX_CONFIG_A, 32'h0);
      axRead(ltd_pkg::IDX_TX_CONFIG_B, 32'h36);
      axRead(ltd_pkg::IDX_TERM_SEL, 32'h0);
      axRead(8'h10, 32'h0, ltd_pkg::RESP_SLVERR);
      axWrite(8'h10, 8'hff, ltd_pkg::RESP_SLVERR);
      s_axi_wstrb <= 4'he;
      axWrite(ltd_pkg::IDX_TX_CONFIG_B, 8'h80);
      s_axi_wstrb <= 4'hf;
      axRead(ltd_pkg::IDX_TX_CONFIG_B, 32'h36);
      axWrite(ltd_pkg::IDX_MODE_CTRL, 8'h08);
      oeIs(1'b1);
      for (int k = 0; k < 8; k++) begin
         axWrite(ltd_pkg::IDX_TX_CONFIG_A, {4'h0, k[3:0]});
         repeat (2) @(posedge clk);
         chk("template", {28'h0, k[3:0]}, {28'h0, pulse_template_sel_r});
      end
      axWrite(ltd_pkg::IDX_TX_CONFIG_A, 8'h01);
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         axWrite(ltd_pkg::IDX_TERM_SEL, {2'h0, k[2:0], rnd[2:0]});
         repeat (2) @(posedge clk);
         chk("txTerm", {29'h0, !k[2], k[1:0]}, {29'h0, txTermInternal_r, txTermOhms_r});
         chk("rxTerm", {29'h0, !rnd[2], rnd[1:0]}, {29'h0, rxTermInternal_r, rxTermOhms_r});
      end
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         txDataPos <= rnd[0];
         txDataNeg <= rnd[1];
         repeat (4) @(posedge clk);
         chk("lineWires", {30'h0, rnd[1:0]}, {30'h0, negWire, posWire});
      end
      for (int c = 0; c < 5; c++) begin
         setCause(c, 1'b1);
         oeIs(1'b0);
         chk("powerDown", {31'h0, c == 4}, {31'h0, txPathPowerDown_r});
         setCause(c, 1'b0);
         oeIs(1'b1);
      end
      for (int m = 1; m < 3; m++) begin
         axWrite(ltd_pkg::IDX_MODE_CTRL, {4'h0, 4'h8 | m[3:0]});
         txClockLost <= 1'b1;
         oeIs(1'b1);
         txClockLost <= 1'b0;
      end
      for (int a = 0; a < 64; a++) begin
         axWrite(ltd_pkg::IDX_WAVE_ADDR, {2'h0, a[5:0]});
         repeat (2) @(posedge clk);
         axRead(ltd_pkg::IDX_WAVE_DATA, {25'h0, expWave(a[5:0])});
      end
      // Playback at unity scale: lock on the one sample 3f, then follow a full lap
      axWrite(ltd_pkg::IDX_TX_CONFIG_A, {4'h0, ltd_pkg::PULSE_T1_LONGEST});
      for (int w = 0; w < 140 && waveSample_r !== 7'h3f; w++) @(posedge clk);
      for (int a = 2; a < 66; a++) begin
         @(posedge clk);
         chk("waveSample", {25'h0, expWave(6'(a))}, {25'h0, waveSample_r});
      end
      axWrite(ltd_pkg::IDX_TX_CONFIG_A, 8'h01);
      rnd = lfsr(rnd);
      axWrite(ltd_pkg::IDX_TX_CONFIG_B, {2'h0, rnd[5:0]});
      axRead(ltd_pkg::IDX_TX_CONFIG_B, {26'h0, rnd[5:0]});
      chk("waveScaled", {25'h0, expScaled(expWave(6'h00), rnd[5:0])}, {25'h0, waveSample_r});
      axWrite(ltd_pkg::IDX_MODE_CTRL, 8'h04);
      oeIs(1'b0);
      chk("waveSample", {25'h0, expWave(6'h00)}, {25'h0, waveSample_r});
      axRead(ltd_pkg::IDX_TX_CONFIG_B, 32'h36);
      final_report();
   end
endmodule : line_termination_driver_control_test
